/* config_boot_clock_manager.sv */
// configuration loader: decrypt, crc check, dual boot, io freeze,
// soft error scan and configuration clock selection
// assumes: one 25 MHz clock, ahb-lite master, storage streams words
`timescale 1ns/1ps
`include "cbcm_consts.svh"

// Notes on behaviour
// - decrypt incoming bitstream with stored 128-bit key
// - freeze user io during reconfiguration
// - reboot from new image on request
// - bad crc or version: fall back, retry
// - crc check the bitstream during configuration
// - soft error scan only while user idle
// - soft error: reload backup or flag error
// - oscillator and config clock never stop
// - power up with 3.1 MHz config clock
// - switch config clock after clock bits arrive
// - seventeen oscillator settings, 2.5 to 163 MHz
// - 80 and 163 MHz never config clock
// - user oscillator defaults to 2.5 MHz
// - oscillator routable into user clock tree
module config_boot_clock_manager (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  input wire logic [127:0] nv_key_i,
  output logic mem_rd_o,
  output logic [23:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_data_i,
  input wire logic mem_last_i,
  output logic cfg_we_o,
  output logic [31:0] cfg_data_o,
  output logic cfg_done_o,
  input wire logic user_active_i,
  output logic scan_rd_o,
  input wire logic scan_valid_i,
  input wire logic [31:0] scan_data_i,
  input wire logic scan_last_i,
  output logic soft_error_o,
  input wire logic [7:0] user_io_i,
  output logic [7:0] user_io_o,
  output logic io_frozen_o,
  output logic config_master_clock_o,
  output logic osc_clk_o,
  output logic osc_route_o,
  output cbcm_pkg::freq_idx_t config_master_clock_sel_o
);
  import cbcm_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one crc-32 step over a whole word, msb first
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ `CBCM_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // half period in system cycles for a table index, never below one
  function automatic logic [7:0] half_cycles(input freq_idx_t idx);
    int f;
    int h;
    unique case (idx)
      5'h00: f = 25;
      5'h01: f = 31;
      5'h02: f = 43;
      5'h03: f = 54;
      5'h04: f = 69;
      5'h05: f = 81;
      5'h06: f = 92;
      5'h07: f = 100;
      5'h08: f = 130;
      5'h09: f = 150;
      5'h0A: f = 200;
      5'h0B: f = 260;
      5'h0C: f = 320;
      5'h0D: f = 400;
      5'h0E: f = 540;
      5'h0F: f = 800;
      default: f = 1630;
    endcase
    h = `CBCM_CLK_100K / (2 * f);
    if (h < 1) begin
      h = 1;
    end
    return h[7:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] addr_r, addr_nxt; // data-phase address
  logic wr_r, wr_nxt; // data-phase write pending
  logic [31:0] rdata_r, rdata_nxt; // read data
  logic [4:0] ctrl_r, ctrl_nxt; // control bits, boot self-clears
  freq_idx_t osc_sel_r, osc_sel_nxt; // user oscillator choice
  logic [15:0] ver_r, ver_nxt; // expected image version
  logic [3:0] irq_stat_r, irq_stat_nxt; // sticky events
  logic [3:0] irq_mask_r, irq_mask_nxt; // event enables
  logic irq_r, irq_nxt;
  cfg_state_e st_r, st_nxt; // sequencer state
  logic backup_r, backup_nxt; // loading the backup image
  logic enc_r, enc_nxt; // image is encrypted
  logic [1:0] kidx_r, kidx_nxt; // key word index
  logic [31:0] crc_r, crc_nxt; // stream crc
  logic [31:0] body_crc_r, body_crc_nxt; // crc of loaded content
  logic [31:0] ref_crc_r, ref_crc_nxt; // reference for scans
  logic [31:0] scrc_r, scrc_nxt; // scan crc
  logic [31:0] cdata_r, cdata_nxt;
  logic cwe_r, cwe_nxt;
  logic [7:0] io_r, io_nxt;
  logic frz_r, frz_nxt;
  logic serr_r, serr_nxt;
  freq_idx_t config_master_clock_r, config_master_clock_nxt; // active config clock index
  freq_idx_t cpend_r, cpend_nxt; // requested config clock index
  logic [7:0] ccnt_r, ccnt_nxt;
  logic config_master_clock_lvl_r, config_master_clock_lvl_nxt;
  logic [7:0] ocnt_r, ocnt_nxt;
  logic osc_lvl_r, osc_lvl_nxt;
  logic route_r, route_nxt;
  logic [3:0] ev; // events of this cycle
  logic [31:0] plain; // decrypted word
  logic [31:0] kword; // key word in use
  logic boot_go; // start a load

  // ----------------------------------------------------------------
  // bus, registers and interrupt: next values
  // ----------------------------------------------------------------
  always_comb begin
    addr_nxt = addr_r;
    wr_nxt = 1'b0;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    ctrl_nxt[`CBCM_CTRL_BOOT] = 1'b0;
    osc_sel_nxt = osc_sel_r;
    ver_nxt = ver_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    // data phase of a write
    if (wr_r) begin
      unique case (addr_r)
        `CBCM_CTRL_OFS: ctrl_nxt = hwdata_i[4:0];
        `CBCM_OSC_OFS: begin
          if (hwdata_i[4:0] <= `CBCM_SEL_MAX) begin
            osc_sel_nxt = hwdata_i[4:0];
          end
        end
        `CBCM_VER_OFS: ver_nxt = hwdata_i[15:0];
        `CBCM_IRQ_STAT_OFS: irq_stat_nxt = irq_stat_r & ~hwdata_i[3:0];
        `CBCM_IRQ_MASK_OFS: irq_mask_nxt = hwdata_i[3:0];
        default: ;
      endcase
    end
    // events set after the clear, so a set wins
    irq_stat_nxt = irq_stat_nxt | ev;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    // address phase
    if (hsel_i && hready_i && htrans_i[1]) begin
      addr_nxt = haddr_i[7:0];
      wr_nxt = hwrite_i;
      unique case (haddr_i[7:0])
        `CBCM_CTRL_OFS: rdata_nxt = {27'h000_0000, ctrl_r};
        `CBCM_OSC_OFS: rdata_nxt = {27'h000_0000, osc_sel_r};
        `CBCM_VER_OFS: rdata_nxt = {16'h0000, ver_r};
        `CBCM_STAT_OFS: rdata_nxt = {21'h00_0000, serr_r, config_master_clock_r, st_r == ST_DONE,
                                    backup_r, st_r};
        `CBCM_IRQ_STAT_OFS: rdata_nxt = {28'h000_0000, irq_stat_r};
        `CBCM_IRQ_MASK_OFS: rdata_nxt = {28'h000_0000, irq_mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration sequencer: next values
  // ----------------------------------------------------------------
  assign kword = nv_key_i[{kidx_r, 5'b00000} +: 32];
  assign plain = enc_r ? (mem_data_i ^ kword) : mem_data_i;
  assign boot_go = ctrl_r[`CBCM_CTRL_BOOT];

  always_comb begin
    st_nxt = st_r;
    backup_nxt = backup_r;
    enc_nxt = enc_r;
    kidx_nxt = kidx_r;
    crc_nxt = crc_r;
    body_crc_nxt = body_crc_r;
    ref_crc_nxt = ref_crc_r;
    scrc_nxt = scrc_r;
    cdata_nxt = cdata_r;
    cwe_nxt = 1'b0;
    cpend_nxt = cpend_r;
    serr_nxt = serr_r;
    ev = 4'h0;
    unique case (st_r)
      // start of a load, image base already chosen by whoever entered
      ST_IDLE: begin
        st_nxt = ST_HDR;
        crc_nxt = `CBCM_CRC_INIT;
        body_crc_nxt = `CBCM_CRC_INIT;
      end
      // header: version, encryption flag, clock choice
      ST_HDR: begin
        if (mem_valid_i) begin
          crc_nxt = crc_step(crc_r, mem_data_i);
          enc_nxt = mem_data_i[`CBCM_HDR_ENC];
          kidx_nxt = 2'b00;
          if (mem_data_i[`CBCM_HDR_SEL_HI:0] <= `CBCM_CONFIG_MASTER_CLOCK_MAX) begin
            cpend_nxt = mem_data_i[`CBCM_HDR_SEL_HI:0];
          end
          if (mem_data_i[`CBCM_HDR_VER_HI:`CBCM_HDR_VER_LO] != ver_r && !backup_r) begin
            // idle one cycle with the read dropped, so a word already
            // fetched from the new image is not taken as the backup header
            st_nxt = ST_IDLE;
            backup_nxt = 1'b1;
            crc_nxt = `CBCM_CRC_INIT;
            ev[`CBCM_IRQ_FAIL] = 1'b1;
            ev[`CBCM_IRQ_FALLBACK] = 1'b1;
          end else begin
            st_nxt = ST_BODY;
          end
        end
      end
      // body words, last word carries the expected crc
      ST_BODY: begin
        if (mem_valid_i && mem_last_i) begin
          if (mem_data_i == crc_r) begin
            st_nxt = ST_DONE;
            ref_crc_nxt = body_crc_r;
            ev[`CBCM_IRQ_DONE] = 1'b1;
          end else if (!backup_r) begin
            st_nxt = ST_HDR;
            backup_nxt = 1'b1;
            ev[`CBCM_IRQ_FAIL] = 1'b1;
            ev[`CBCM_IRQ_FALLBACK] = 1'b1;
          end else begin
            st_nxt = ST_FAIL;
            ev[`CBCM_IRQ_FAIL] = 1'b1;
          end
          crc_nxt = `CBCM_CRC_INIT;
          body_crc_nxt = `CBCM_CRC_INIT;
        end else if (mem_valid_i) begin
          crc_nxt = crc_step(crc_r, mem_data_i);
          body_crc_nxt = crc_step(body_crc_r, plain);
          cdata_nxt = plain;
          cwe_nxt = 1'b1;
          kidx_nxt = kidx_r + 2'b01;
        end
      end
      // user mode: soft error scan while the user logic rests
      ST_DONE: begin
        if (!ctrl_r[`CBCM_CTRL_SCAN] || user_active_i) begin
          scrc_nxt = `CBCM_CRC_INIT;
        end else if (scan_valid_i) begin
          scrc_nxt = crc_step(scrc_r, scan_data_i);
          if (scan_last_i) begin
            scrc_nxt = `CBCM_CRC_INIT;
            if (crc_step(scrc_r, scan_data_i) != ref_crc_r) begin
              ev[`CBCM_IRQ_SOFTERR] = 1'b1;
              if (ctrl_r[`CBCM_CTRL_RELOAD]) begin
                st_nxt = ST_HDR;
                backup_nxt = 1'b1;
                crc_nxt = `CBCM_CRC_INIT;
              end else begin
                serr_nxt = 1'b1;
              end
            end
          end
        end
      end
      // both images bad: wait for software
      ST_FAIL: ;
      default: st_nxt = ST_IDLE;
    endcase
    // reboot from the newly stored image at any time
    if (boot_go) begin
      st_nxt = ST_IDLE;
      backup_nxt = 1'b0;
      serr_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // io freeze and clocks: next values
  // ----------------------------------------------------------------
  always_comb begin
    frz_nxt = ctrl_r[`CBCM_CTRL_FREEZE] && (st_nxt != ST_DONE);
    io_nxt = frz_r ? io_r : user_io_i;
    route_nxt = ctrl_r[`CBCM_CTRL_ROUTE];
    // config clock divider, free running
    config_master_clock_nxt = config_master_clock_r;
    config_master_clock_lvl_nxt = config_master_clock_lvl_r;
    ccnt_nxt = ccnt_r + 8'h01;
    if (ccnt_r + 8'h01 >= half_cycles(config_master_clock_r)) begin
      ccnt_nxt = 8'h00;
      config_master_clock_lvl_nxt = !config_master_clock_lvl_r;
      // new rate only at the end of a whole low-high period
      if (config_master_clock_lvl_r) begin
        config_master_clock_nxt = cpend_r;
      end
    end
    // user oscillator divider, free running
    osc_lvl_nxt = osc_lvl_r;
    ocnt_nxt = ocnt_r + 8'h01;
    if (ocnt_r + 8'h01 >= half_cycles(osc_sel_r)) begin
      ocnt_nxt = 8'h00;
      osc_lvl_nxt = !osc_lvl_r;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= 5'h00;
      osc_sel_r <= `CBCM_OSC_DEF;
      ver_r <= `CBCM_VER_RST;
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
      irq_r <= 1'b0;
      st_r <= ST_IDLE;
      backup_r <= 1'b0;
      enc_r <= 1'b0;
      kidx_r <= 2'b00;
      crc_r <= `CBCM_CRC_INIT;
      body_crc_r <= `CBCM_CRC_INIT;
      ref_crc_r <= `CBCM_CRC_INIT;
      scrc_r <= `CBCM_CRC_INIT;
      cdata_r <= 32'h0000_0000;
      cwe_r <= 1'b0;
      io_r <= 8'h00;
      frz_r <= 1'b0;
      serr_r <= 1'b0;
      config_master_clock_r <= `CBCM_CONFIG_MASTER_CLOCK_DEF;
      cpend_r <= `CBCM_CONFIG_MASTER_CLOCK_DEF;
      ccnt_r <= 8'h00;
      config_master_clock_lvl_r <= 1'b0;
      ocnt_r <= 8'h00;
      osc_lvl_r <= 1'b0;
      route_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      osc_sel_r <= osc_sel_nxt;
      ver_r <= ver_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
      st_r <= st_nxt;
      backup_r <= backup_nxt;
      enc_r <= enc_nxt;
      kidx_r <= kidx_nxt;
      crc_r <= crc_nxt;
      body_crc_r <= body_crc_nxt;
      ref_crc_r <= ref_crc_nxt;
      scrc_r <= scrc_nxt;
      cdata_r <= cdata_nxt;
      cwe_r <= cwe_nxt;
      io_r <= io_nxt;
      frz_r <= frz_nxt;
      serr_r <= serr_nxt;
      config_master_clock_r <= config_master_clock_nxt;
      cpend_r <= cpend_nxt;
      ccnt_r <= ccnt_nxt;
      config_master_clock_lvl_r <= config_master_clock_lvl_nxt;
      ocnt_r <= ocnt_nxt;
      osc_lvl_r <= osc_lvl_nxt;
      route_r <= route_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, from flip-flops except the constant bus responses and scan_rd_o, which also decodes user_active_i
  // ----------------------------------------------------------------
  assign hrdata_o = rdata_r;
  assign hreadyout_o = rst_n_i | 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = irq_r;
  // image base: backup is kept apart from the new image
  assign mem_rd_o = (st_r == ST_HDR) || (st_r == ST_BODY);
  assign mem_addr_o = backup_r ? `CBCM_BACKUP_BASE : `CBCM_NEW_BASE;
  assign cfg_we_o = cwe_r;
  assign cfg_data_o = cdata_r;
  assign cfg_done_o = (st_r == ST_DONE);
  assign scan_rd_o = (st_r == ST_DONE) && ctrl_r[`CBCM_CTRL_SCAN] && !user_active_i;
  assign soft_error_o = serr_r;
  assign user_io_o = io_r;
  assign io_frozen_o = frz_r;
  assign config_master_clock_o = config_master_clock_lvl_r;
  assign osc_clk_o = osc_lvl_r;
  assign osc_route_o = route_r;
  assign config_master_clock_sel_o = config_master_clock_r;
endmodule

/* cbcm_consts.svh */
// constants of the configuration, boot and clock manager
// assumes: included by bare name from the package and the module
`ifndef CBCM_CONSTS_SVH
`define CBCM_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets (low address byte)
// ----------------------------------------------------------------
`define CBCM_CTRL_OFS 8'h00
`define CBCM_OSC_OFS 8'h04
`define CBCM_VER_OFS 8'h08
`define CBCM_STAT_OFS 8'h0C
`define CBCM_IRQ_STAT_OFS 8'h10
`define CBCM_IRQ_MASK_OFS 8'h14

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define CBCM_CTRL_BOOT 0
`define CBCM_CTRL_FREEZE 1
`define CBCM_CTRL_SCAN 2
`define CBCM_CTRL_RELOAD 3
`define CBCM_CTRL_ROUTE 4

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define CBCM_IRQ_DONE 0
`define CBCM_IRQ_FAIL 1
`define CBCM_IRQ_FALLBACK 2
`define CBCM_IRQ_SOFTERR 3

// ----------------------------------------------------------------
// bitstream header fields and image bases
// ----------------------------------------------------------------
`define CBCM_HDR_VER_HI 31
`define CBCM_HDR_VER_LO 16
`define CBCM_HDR_ENC 8
`define CBCM_HDR_SEL_HI 4
`define CBCM_NEW_BASE 24'h00_0000
`define CBCM_BACKUP_BASE 24'h10_0000

// ----------------------------------------------------------------
// reset values, clock table and crc
// ----------------------------------------------------------------
`define CBCM_VER_RST 16'h0001
`define CBCM_CONFIG_MASTER_CLOCK_DEF 5'h01
`define CBCM_OSC_DEF 5'h00
`define CBCM_SEL_MAX 5'h10
`define CBCM_CONFIG_MASTER_CLOCK_MAX 5'h0E
`define CBCM_CLK_100K 250
`define CBCM_CRC_POLY 32'h04C1_1DB7
`define CBCM_CRC_INIT 32'hFFFF_FFFF

`endif

/* cbcm_pkg.sv */
// types shared by the configuration, boot and clock manager
// assumes: constants header in the same folder
package cbcm_pkg;
`include "cbcm_consts.svh"

  // configuration sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_BODY, ST_DONE, ST_FAIL
  } cfg_state_e;

  // index into the 17-entry oscillator frequency table
  typedef logic [4:0] freq_idx_t;
endpackage

/* cbcm_chk.sv */
// checker of the configuration, boot and clock manager ports
// assumes: bound to the top module, one clock, synchronous low reset
`timescale 1ns/1ps
module cbcm_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mem_rd_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic cfg_we_o,
  input wire logic cfg_done_o,
  input wire logic user_active_i,
  input wire logic scan_rd_o,
  input wire logic [7:0] user_io_o,
  input wire logic io_frozen_o,
  input wire logic config_master_clock_o,
  input wire logic osc_clk_o,
  input wire cbcm_pkg::freq_idx_t config_master_clock_sel_o
);
  import cbcm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // clock activity: slowest half period is five cycles
  // ----
  sequence s_cm_low;
    ##[1:6] !config_master_clock_o;
  endsequence
  sequence s_cm_high;
    ##[1:6] config_master_clock_o;
  endsequence
  a_config_master_clock_high_falls: assert property (config_master_clock_o |-> s_cm_low)
    else $error("config clock stuck high");
  a_config_master_clock_low_rises: assert property (!config_master_clock_o |-> s_cm_high)
    else $error("config clock stuck low");
  a_osc_keeps_running: assert property (osc_clk_o |-> ##[1:6] !osc_clk_o)
    else $error("oscillator output stuck high");
  a_config_master_clock_reset_default: assert property ($rose(rst_n_i) |-> config_master_clock_sel_o == 5'h01)
    else $error("config clock index not default after reset");
  a_config_master_clock_valid_index: assert property (config_master_clock_sel_o <= 5'h0E)
    else $error("config clock index out of range");
  a_config_master_clock_switch_low: assert property ($changed(config_master_clock_sel_o) |-> !config_master_clock_o)
    else $error("config clock index changed outside low phase");
  a_frozen_io_hold: assert property (io_frozen_o && $past(io_frozen_o) |-> $stable(user_io_o))
    else $error("user io moved while frozen");
  a_scan_user_idle: assert property (scan_rd_o |-> !user_active_i && cfg_done_o)
    else $error("scan while user logic active or unconfigured");
  a_load_after_reset: assert property ($rose(rst_n_i) |-> ##[1:2] mem_rd_o)
    else $error("no load after reset");
  a_mem_two_bases: assert property (mem_rd_o |-> mem_addr_o inside {24'h00_0000, 24'h10_0000})
    else $error("image base unknown");
  a_word_from_store: assert property (cfg_we_o |-> $past(mem_rd_o) && $past(mem_valid_i))
    else $error("config word without storage word");
endmodule

/* cbcm_storage.sv */
// storage model: update image at base zero, backup image apart
// assumes: bench fills both queues before they are read
`timescale 1ns/1ps
module cbcm_storage (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rd_i,
  input wire logic [23:0] addr_i,
  output logic valid_o,
  output logic [31:0] data_o,
  output logic last_o
);
  logic [31:0] img_new[$]; // update image
  logic [31:0] img_bak[$]; // backup image, never overwritten
  logic [31:0] img[$];
  logic [23:0] addr_q = '0;
  logic tick = 1'b0;
  int idx = 0;
  initial begin
    valid_o = 1'b0;
    data_o = '0;
    last_o = 1'b0;
  end
  // ----
  // one word a cycle, every other cycle stalled when slow
  // ----
  always @(posedge clk_i) begin
    if (addr_i == 24'h10_0000) img = img_bak;
    else img = img_new;
    tick <= ~tick;
    addr_q <= addr_i;
    if (!rd_i || addr_i != addr_q) idx = 0;
    else if (valid_o) idx = idx + 1;
    if (rd_i && addr_i == addr_q && idx < img.size() && !(slow_i && tick)) begin
      valid_o <= 1'b1;
      data_o <= img[idx];
      last_o <= (idx == img.size() - 1);
    end else begin
      // released bus shows no stale word
      valid_o <= 1'b0;
      data_o <= ~data_o;
      last_o <= 1'b0;
    end
  end
endmodule

/* config_boot_clock_manager_bench.sv */
// self-checking bench: ahb-lite master, storage model, scan feed
// assumes: package, design, storage model and checker compiled first
`timescale 1ns/1ps
module config_boot_clock_manager_bench;
  import cbcm_pkg::*;
  // ----
  // signals and reference state
  // ----
  logic clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, user_active_i = 1, slow = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, scan_data_i = 0, cfg_data_o, mem_data_i;
  logic [1:0] htrans_i = 0;
  logic [127:0] nv_key_i = 0;
  logic scan_valid_i = 0, scan_last_i = 0, hready_i, hresp_o, irq_o, mem_rd_o, mem_valid_i;
  logic mem_last_i, cfg_we_o, cfg_done_o, scan_rd_o, soft_error_o, io_frozen_o, osc_route_o;
  logic config_master_clock_o, osc_clk_o;
  logic [7:0] user_io_i = 0, user_io_o;
  logic [23:0] mem_addr_o;
  freq_idx_t config_master_clock_sel_o;
  logic [31:0] seed = 32'h0000_6A6F, img[$], plain[$], exp_new[$], exp_bak[$], got[$], rd;
  int n_errors = 0, comparisons = 0;

  always #20 clk_i = ~clk_i;

  config_boot_clock_manager u_config_boot_clock_manager (
    .clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'b010), .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o(hready_i), .hresp_o, .irq_o, .nv_key_i, .mem_rd_o,
    .mem_addr_o, .mem_valid_i, .mem_data_i, .mem_last_i, .cfg_we_o, .cfg_data_o, .cfg_done_o,
    .user_active_i, .scan_rd_o, .scan_valid_i, .scan_data_i, .scan_last_i, .soft_error_o,
    .user_io_i, .user_io_o, .io_frozen_o, .config_master_clock_o, .osc_clk_o, .osc_route_o,
    .config_master_clock_sel_o);
  cbcm_storage u_cbcm_storage (.clk_i, .slow_i(slow), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .valid_o(mem_valid_i), .data_o(mem_data_i), .last_o(mem_last_i));

  // collect every configuration word the block writes
  always @(posedge clk_i) if (cfg_we_o === 1'b1) got.push_back(cfg_data_o);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0);
    return seed;
  endfunction
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0);
    return c;
  endfunction
  // image with header, random body and trailing crc; plain holds expected words
  task automatic build(input logic [15:0] ver, input logic [4:0] sel, input logic enc,
    input logic bad);
    logic [31:0] c, w;
    img = {{ver, 7'h00, enc, 3'h0, sel}};
    plain = {};
    c = crc(32'hFFFF_FFFF, img[0]);
    for (int i = 0; i < 6; i++) begin
      w = rnd();
      img.push_back(w);
      plain.push_back(enc ? w ^ nv_key_i[32*(i%4) +: 32] : w);
      c = crc(c, w);
    end
    img.push_back(bad ? ~c : c);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic cmpq(input logic [31:0] q[$]);
    foreach (q[i]) check("config word", got[got.size() - q.size() + i], q[i]);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_i);
    hsel_i <= 1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1 && ++n < 20);
    htrans_i <= 2'b00;
    hsel_i <= 0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hready_i !== 1'b1 && ++n < 40);
    rd = hrdata_o;
    check("bus response", hresp_o, 0);
    if (n >= 20) check("bus wait", n, 0);
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] want);
    ahb(0, a, 0);
    check(w, rd, want);
  endtask
  task automatic wait_done();
    int n = 0;
    repeat (2) @(posedge clk_i);
    while (cfg_done_o !== 1'b1 && n++ < 400) @(posedge clk_i);
    check("load done", cfg_done_o, 1);
  endtask
  task automatic scan(input logic [31:0] q[$], input logic bad);
    foreach (q[i]) begin
      scan_valid_i <= 1;
      scan_data_i <= (i == 0 && bad) ? ~q[i] : q[i];
      scan_last_i <= (i == q.size() - 1);
      @(posedge clk_i);
    end
    scan_valid_i <= 0;
    scan_last_i <= 0;
    scan_data_i <= ~scan_data_i;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  // ----
  // main sequence
  // ----
  initial begin
    for (int i = 0; i < 4; i++) nv_key_i[32*i +: 32] = rnd();
    build(16'h0001, 5'h03, 1'b1, 1'b0);
    u_cbcm_storage.img_new = img;
    exp_new = plain;
    build(16'h0007, 5'h0F, 1'b0, 1'b0);
    u_cbcm_storage.img_bak = img;
    exp_bak = plain;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    check("clock index", config_master_clock_sel_o, 5'h01);
    wait_done();
    cmpq(exp_new);
    for (int n = 0; n < 20 && config_master_clock_sel_o !== 5'h03; n++) @(posedge clk_i);
    check("clock index", config_master_clock_sel_o, 5'h03);
    rchk("osc select", 8'h04, 0);
    ahb(1, 8'h04, 16);
    rchk("osc select", 8'h04, 16);
    ahb(1, 8'h04, 17);
    rchk("osc select", 8'h04, 16);
    rchk("version", 8'h08, 1);
    ahb(1, 8'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h1C, 0);
    ahb(1, 8'h00, 32'h10);
    rchk("control", 8'h00, 32'h10);
    check("osc route", osc_route_o, 1);
    rchk("irq status", 8'h10, 1);
    check("irq line", irq_o, 0);
    ahb(1, 8'h14, 1);
    rchk("irq mask", 8'h14, 1);
    check("irq line", irq_o, 1);
    ahb(1, 8'h10, 1);
    rchk("irq status", 8'h10, 0);
    check("irq line", irq_o, 0);
    // wrong version on a fast store, then bad crc on a slow one: both fall back
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      build(k ? 16'h0001 : 16'h0002, 5'h03, 1'b1, k[0]);
      u_cbcm_storage.img_new = img;
      got = {};
      user_io_i <= 8'h3C;
      ahb(1, 8'h00, 32'h3);
      repeat (3) @(posedge clk_i);
      check("frozen", io_frozen_o, 1);
      rd = rnd();
      user_io_i <= rd[7:0];
      repeat (2) @(posedge clk_i);
      check("user io", user_io_o, 8'h3C);
      wait_done();
      check("word count", got.size(), k ? 12 : 6);
      cmpq(exp_bak);
      check("clock index", config_master_clock_sel_o, 5'h03);
      ahb(0, 8'h0C, 0);
      check("status", rd[3:0], 4'hB);
      rchk("irq status", 8'h10, 32'h7);
      ahb(1, 8'h10, 32'hF);
    end
    build(16'h0001, 5'h03, 1'b1, 1'b0);
    u_cbcm_storage.img_new = img;
    exp_new = plain;
    ahb(1, 8'h00, 32'h1);
    wait_done();
    cmpq(exp_new);
    ahb(0, 8'h0C, 0);
    check("status", rd[3:0], 4'h3);
    // soft error scan: match, mismatch with reload, mismatch with flag
    ahb(1, 8'h00, 32'h4);
    @(posedge clk_i);
    check("scan read", scan_rd_o, 0);
    user_active_i <= 0;
    repeat (2) @(posedge clk_i);
    check("scan read", scan_rd_o, 1);
    for (int r = 0; r < 3; r++) begin
      ahb(1, 8'h10, 32'hF);
      ahb(1, 8'h00, r == 1 ? 32'hC : 32'h4);
      if (r == 2) scan(exp_bak, 1'b1);
      else scan(exp_new, r > 0);
      repeat (4) @(posedge clk_i);
      check("soft error", soft_error_o, r == 2);
      check("reload", mem_rd_o, r == 1);
      ahb(0, 8'h10, 0);
      check("soft error irq", rd[3], r > 0);
      if (r == 1) begin
        wait_done();
        ahb(0, 8'h0C, 0);
        check("status", rd[3:0], 4'hB);
      end
    end
    print_verdict();
  end
endmodule

bind config_boot_clock_manager cbcm_chk u_cbcm_chk (.clk_i, .rst_n_i, .mem_rd_o, .mem_addr_o,
  .mem_valid_i, .cfg_we_o, .cfg_done_o, .user_active_i, .scan_rd_o, .user_io_o, .io_frozen_o,
  .config_master_clock_o, .osc_clk_o, .config_master_clock_sel_o);
